// ---- hdl/cmr_engine.sv ----
// Move engine: control, register list and peripheral byte moves
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Direction 0 copies control register to general, 1 the reverse.
// - Type bit picks data (0) or address (1) register by number.
// - Codes 000, 001, 800, 801 pick the four control registers.
// - Any other control code raises illegal instruction, no transfer.
// - List move transfers only masked registers, consecutive memory.
// - Size picks word or long; word loads are sign-extended.
// - Only control, predecrement and postincrement modes; mode sets behaviour.
// - Control mode starts at address, steps by length, D0..D7, A0..A7.
// - Predecrement stores only, from address minus length, A7..A0, D7..D0.
// - Predecrement leaves last stored address; own image is decremented value.
// - Postincrement loads only; register ends at last address plus length.
// - Postincrement register in list keeps fetched value plus length.
// - Opcode direction 0 stores, 1 loads; size 0 word, 1 long.
// - Store modes: 010, 100, 101, 110, absolute short or long.
// - Load modes: 010, 011, 101, 110, absolute, PC relative.
// - Control and postincrement mask: bits 0-7 D0-D7, 8-15 A0-A7.
// - Predecrement mask reversed: bit 15 D0 down to bit 0 A7.
// - Loads end with one extra read just above the last image.
// - Peripheral move steps address by two per byte.
// - Peripheral move sends most significant byte first.
// - Peripheral address is address register plus signed displacement.
// - Even address uses upper data half, odd the lower half.
// - Control move is 32 bits; unimplemented bits read zero.
// - Control move needs supervisor state, else it traps.
// - Peripheral opmodes 100, 101 load, 110, 111 store word/long.
module cmr_engine
  import cmr_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output cmr_mreq_s        MEM_REQ,
  output logic             MEM_VALID,
  input  wire logic        MEM_READY,
  input  wire logic [31:0] MEM_RDATA
);
  // ****************************************
  // State
  // ****************************************
  cmr_state_e        st_q, st_d;
  logic [31:0]       rf_q [16];
  logic [31:0]       rf_d [16];
  logic [15:0]       op_q, op_d;
  logic [15:0]       ext_q, ext_d;
  logic [31:0]       ea_q, ea_d;
  logic              sup_q, sup_d;
  logic [3:0]        sts_q, sts_d;
  logic [3:0]        sel_q, sel_d;
  logic [SPACE_W-1:0] sfc_q, sfc_d;
  logic [SPACE_W-1:0] dfc_q, dfc_d;
  logic [31:0]       usp_q, usp_d;
  logic [31:0]       vbr_q, vbr_d;
  logic [15:0]       mask_q, mask_d;
  logic [31:0]       addr_q, addr_d;
  logic [31:0]       base_q, base_d;
  logic [31:0]       sh_q, sh_d;
  logic [2:0]        cnt_q, cnt_d;
  logic              anl_q, anl_d;
  logic              mv_q, mv_d;
  cmr_mreq_s         rq_q, rq_d;

  // ****************************************
  // Decode of held instruction
  // ****************************************
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit;
  logic [31:0] rdv;
  logic        to_reg;
  logic        long_sz;
  logic [2:0]  ea_mode;
  logic [3:0]  an_idx;
  logic [31:0] len;
  logic        predec;
  logic        mode_ok;
  logic        found;
  logic [3:0]  bit_idx;
  logic [3:0]  reg_idx;
  logic [3:0]  gr_idx;
  logic        pb_load;
  logic        is_crm;
  logic        is_rlm;
  logic        is_pbm;
  logic [7:0]  pb_byte;

  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign rd = acc && !PWRITE;
  assign is_crm = (op_q & CRM_MASK) == CRM_VAL;
  assign is_rlm = (op_q & RLM_MASK) == RLM_VAL;
  assign is_pbm = (op_q & PBM_MASK) == PBM_VAL;
  assign to_reg = op_q[10];
  assign long_sz = op_q[6];
  assign len = long_sz ? LEN_LONG : LEN_WORD;
  assign ea_mode = op_q[5:3];
  assign an_idx = A_BASE | {1'b0, op_q[2:0]};
  assign predec = ea_mode == MODE_PREDEC;
  assign gr_idx = {ext_q[15], ext_q[14:12]};
  assign pb_load = !op_q[7];
  // Predecrement walks the mask reversed
  assign reg_idx = predec ? ~bit_idx : bit_idx;
  // Byte from the half of the bus that the address selects
  assign pb_byte = addr_q[0] ? MEM_RDATA[7:0]
                             : MEM_RDATA[15:8];

  // Next register in transfer order
  cmr_first_set #(
    .W  (16),
    .IW (4)
  ) u_first (
    .vec   (mask_q),
    .found (found),
    .idx   (bit_idx)
  );

  // Allowed addressing modes
  cmr_mode_check u_mode (
    .mode   (ea_mode),
    .reg_f  (op_q[2:0]),
    .to_reg (to_reg),
    .ok     (mode_ok)
  );

  // ****************************************
  // APB read mux
  // ****************************************
  always_comb begin
    hit = 1'b1;
    rdv = '0;
    case (PADDR)
      OFS_OPWORD: rdv = {16'h0, op_q};
      OFS_EXTWORD: rdv = {16'h0, ext_q};
      OFS_EADDR: rdv = ea_q;
      OFS_CTRL: rdv = {31'h0, sup_q};
      OFS_STATUS: rdv = {28'h0, sts_q};
      OFS_GR_SEL: rdv = {28'h0, sel_q};
      OFS_GR_DATA: rdv = rf_q[sel_q];
      default: hit = 1'b0;
    endcase
  end

  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit;
  assign PRDATA = rd ? rdv : '0;
  assign MEM_VALID = mv_q;
  assign MEM_REQ = rq_q;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    rf_d = rf_q;
    op_d = op_q;
    ext_d = ext_q;
    ea_d = ea_q;
    sup_d = sup_q;
    sts_d = sts_q;
    sel_d = sel_q;
    sfc_d = sfc_q;
    dfc_d = dfc_q;
    usp_d = usp_q;
    vbr_d = vbr_q;
    mask_d = mask_q;
    addr_d = addr_q;
    base_d = base_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    anl_d = anl_q;
    mv_d = mv_q;
    rq_d = rq_q;
    // Software writes; status flags clear by writing one
    if (wr) begin
      case (PADDR)
        OFS_OPWORD: if (st_q == S_IDLE) op_d = PWDATA[15:0];
        OFS_EXTWORD: if (st_q == S_IDLE) ext_d = PWDATA[15:0];
        OFS_EADDR: if (st_q == S_IDLE) ea_d = PWDATA;
        OFS_CTRL: begin
          sup_d = PWDATA[CTRL_SUPER];
          if (PWDATA[CTRL_GO] && st_q == S_IDLE) begin
            st_d = S_DEC;
          end
        end
        OFS_STATUS: sts_d[ST_PRIV:ST_DONE] =
          sts_q[ST_PRIV:ST_DONE] & ~PWDATA[ST_PRIV:ST_DONE];
        OFS_GR_SEL: sel_d = PWDATA[3:0];
        OFS_GR_DATA: if (st_q == S_IDLE) rf_d[sel_q] = PWDATA;
        default: ;
      endcase
    end
    // Engine sequence; its flag sets follow the clear
    case (st_q)
      S_IDLE: ;
      S_DEC: begin
        st_d = S_DONE;
        if (is_crm) begin
          if (!sup_q) begin
            sts_d[ST_PRIV] = 1'b1;
          end else if (!op_q[0]) begin
            case (ext_q[11:0])
              CR_SRC_SPACE:
                rf_d[gr_idx] = {29'h0, sfc_q};
              CR_DST_SPACE:
                rf_d[gr_idx] = {29'h0, dfc_q};
              CR_USER_SP: rf_d[gr_idx] = usp_q;
              CR_VEC_BASE: rf_d[gr_idx] = vbr_q;
              default: sts_d[ST_ILLEGAL] = 1'b1;
            endcase
          end else begin
            case (ext_q[11:0])
              CR_SRC_SPACE:
                sfc_d = rf_q[gr_idx][SPACE_W-1:0];
              CR_DST_SPACE:
                dfc_d = rf_q[gr_idx][SPACE_W-1:0];
              CR_USER_SP: usp_d = rf_q[gr_idx];
              CR_VEC_BASE: vbr_d = rf_q[gr_idx];
              default: sts_d[ST_ILLEGAL] = 1'b1;
            endcase
          end
        end else if (is_rlm) begin
          if (!mode_ok) begin
            sts_d[ST_ILLEGAL] = 1'b1;
          end else begin
            mask_d = ext_q;
            anl_d = 1'b0;
            // Register modes use the register, others the given address
            if (ea_mode == MODE_IND || ea_mode == MODE_POSTINC ||
                predec) begin
              addr_d = rf_q[an_idx];
            end else begin
              addr_d = ea_q;
            end
            base_d = rf_q[an_idx] - len;
            st_d = S_LIST;
          end
        end else if (is_pbm) begin
          // Register plus sign-extended displacement
          addr_d = rf_q[an_idx] +
                   {{16{ext_q[15]}}, ext_q};
          cnt_d = op_q[6] ? PB_LONG_N : PB_WORD_N;
          sh_d = op_q[6] ? rf_q[{1'b0, op_q[11:9]}]
                         : {rf_q[{1'b0, op_q[11:9]}][15:0], 16'h0};
          st_d = S_PBYTE;
        end else begin
          sts_d[ST_ILLEGAL] = 1'b1;
        end
      end
      S_LIST: begin
        if (!mv_q) begin
          if (found) begin
            // Issue the next register transfer
            mv_d = 1'b1;
            rq_d.we = !to_reg;
            rq_d.size = long_sz ? SZ_LONG : SZ_WORD;
            rq_d.addr = predec ? addr_q - len : addr_q;
            if (predec && reg_idx == an_idx) begin
              rq_d.wdata = base_q;
            end else begin
              rq_d.wdata = rf_q[reg_idx];
            end
          end else if (to_reg) begin
            // Trailing read at the next address
            mv_d = 1'b1;
            rq_d.we = 1'b0;
            rq_d.size = long_sz ? SZ_LONG : SZ_WORD;
            rq_d.addr = addr_q;
            st_d = S_XRD;
          end else begin
            if (predec) begin
              rf_d[an_idx] = addr_q;
            end
            st_d = S_DONE;
          end
        end else if (MEM_READY) begin
          mv_d = 1'b0;
          mask_d[bit_idx] = 1'b0;
          if (predec) begin
            addr_d = addr_q - len;
          end else begin
            addr_d = addr_q + len;
          end
          if (to_reg) begin
            if (long_sz) begin
              rf_d[reg_idx] = MEM_RDATA;
            end else begin
              rf_d[reg_idx] = {{16{MEM_RDATA[15]}},
                               MEM_RDATA[15:0]};
            end
            if (ea_mode == MODE_POSTINC && reg_idx == an_idx) begin
              anl_d = 1'b1;
              rf_d[reg_idx] = (long_sz ? MEM_RDATA
                : {{16{MEM_RDATA[15]}}, MEM_RDATA[15:0]}) + len;
            end
          end
        end
      end
      S_XRD: begin
        if (MEM_READY) begin
          mv_d = 1'b0;
          // Final address unless the register was itself loaded
          if (ea_mode == MODE_POSTINC && !anl_q) begin
            rf_d[an_idx] = addr_q;
          end
          st_d = S_DONE;
        end
      end
      S_PBYTE: begin
        if (!mv_q) begin
          if (cnt_q != 3'h0) begin
            mv_d = 1'b1;
            rq_d.we = !pb_load;
            rq_d.size = SZ_BYTE;
            rq_d.addr = addr_q;
            // Same byte on both halves; address picks the lane
            rq_d.wdata = {4{sh_q[31:24]}};
          end else begin
            if (pb_load) begin
              if (op_q[6]) begin
                rf_d[{1'b0, op_q[11:9]}] = sh_q;
              end else begin
                rf_d[{1'b0, op_q[11:9]}][15:0] = sh_q[15:0];
              end
            end
            st_d = S_DONE;
          end
        end else if (MEM_READY) begin
          mv_d = 1'b0;
          addr_d = addr_q + PB_STEP;
          cnt_d = cnt_q - 3'h1;
          // High byte first in both directions
          sh_d = pb_load ? {sh_q[23:0], pb_byte}
                         : {sh_q[23:0], 8'h0};
        end
      end
      S_DONE: begin
        sts_d[ST_DONE] = 1'b1;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    sts_d[ST_BUSY] = st_d != S_IDLE;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= S_IDLE;
      for (int i = 0; i < 16; i++) begin
        rf_q[i] <= '0;
      end
      op_q <= '0;
      ext_q <= '0;
      ea_q <= '0;
      sup_q <= 1'b0;
      sts_q <= '0;
      sel_q <= '0;
      sfc_q <= '0;
      dfc_q <= '0;
      usp_q <= '0;
      vbr_q <= '0;
      mask_q <= '0;
      addr_q <= '0;
      base_q <= '0;
      sh_q <= '0;
      cnt_q <= '0;
      anl_q <= 1'b0;
      mv_q <= 1'b0;
      rq_q <= '0;
    end else begin
      st_q <= st_d;
      rf_q <= rf_d;
      op_q <= op_d;
      ext_q <= ext_d;
      ea_q <= ea_d;
      sup_q <= sup_d;
      sts_q <= sts_d;
      sel_q <= sel_d;
      sfc_q <= sfc_d;
      dfc_q <= dfc_d;
      usp_q <= usp_d;
      vbr_q <= vbr_d;
      mask_q <= mask_d;
      addr_q <= addr_d;
      base_q <= base_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      anl_q <= anl_d;
      mv_q <= mv_d;
      rq_q <= rq_d;
    end
  end
endmodule : cmr_engine
`default_nettype wire

// ---- hdl/cmr_first_set.sv ----
// Finder of the lowest set bit of a vector
`timescale 1ns/1ns
`default_nettype none
module cmr_first_set
  import cmr_pkg::*;
#(
  parameter int W  = 16,
  parameter int IW = 4
) (
  input  wire logic [W-1:0]  vec,
  output logic               found,
  output logic [IW-1:0]      idx
);
  // Scan from the top so the lowest set bit wins
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (vec[i]) begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule : cmr_first_set
`default_nettype wire

// ---- hdl/cmr_mode_check.sv ----
// Legal addressing modes of the register list move
`timescale 1ns/1ns
`default_nettype none
module cmr_mode_check
  import cmr_pkg::*;
(
  input  wire logic [2:0] mode,
  input  wire logic [2:0] reg_f,
  input  wire logic       to_reg,
  output logic            ok
);
  // Store and load accept different mode sets
  always_comb begin
    case (mode)
      MODE_IND, MODE_DISP, MODE_INDEX: ok = 1'b1;
      MODE_PREDEC: ok = !to_reg;
      MODE_POSTINC: ok = to_reg;
      MODE_EXT: ok = to_reg ? (reg_f <= EXT_PC_IDX)
                            : (reg_f <= EXT_ABS_L);
      default: ok = 1'b0;
    endcase
  end
endmodule : cmr_mode_check
`default_nettype wire

// ---- hdl/cmr_pkg.sv ----
// Shared constants and types of the move instruction engine
package cmr_pkg;
  // ****************************************
  // APB register offsets
  // ****************************************
  localparam logic [7:0] OFS_OPWORD = 8'h00;
  localparam logic [7:0] OFS_EXTWORD = 8'h04;
  localparam logic [7:0] OFS_EADDR = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_GR_SEL = 8'h14;
  localparam logic [7:0] OFS_GR_DATA = 8'h18;
  // CTRL and STATUS bit positions
  localparam int CTRL_SUPER = 0;
  localparam int CTRL_GO = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_PRIV = 3;
  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [15:0] CRM_MASK = 16'hfffe;
  localparam logic [15:0] CRM_VAL = 16'h4e7a;
  localparam logic [15:0] RLM_MASK = 16'hfb80;
  localparam logic [15:0] RLM_VAL = 16'h4880;
  localparam logic [15:0] PBM_MASK = 16'hf138;
  localparam logic [15:0] PBM_VAL = 16'h0108;
  // Control register codes
  localparam logic [11:0] CR_SRC_SPACE = 12'h000;
  localparam logic [11:0] CR_DST_SPACE = 12'h001;
  localparam logic [11:0] CR_USER_SP = 12'h800;
  localparam logic [11:0] CR_VEC_BASE = 12'h801;
  localparam int SPACE_W = 3;
  // Addressing modes
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_POSTINC = 3'h3;
  localparam logic [2:0] MODE_PREDEC = 3'h4;
  localparam logic [2:0] MODE_DISP = 3'h5;
  localparam logic [2:0] MODE_INDEX = 3'h6;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] EXT_ABS_L = 3'h1;
  localparam logic [2:0] EXT_PC_IDX = 3'h3;
  // Operand lengths in bytes and bus sizes
  localparam logic [31:0] LEN_WORD = 32'h2;
  localparam logic [31:0] LEN_LONG = 32'h4;
  localparam logic [31:0] PB_STEP = 32'h2;
  localparam logic [2:0] PB_WORD_N = 3'h2;
  localparam logic [2:0] PB_LONG_N = 3'h4;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [3:0] A_BASE = 4'h8;
  // Engine states
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_DEC   = 3'b001,
    S_LIST  = 3'b010,
    S_XRD   = 3'b011,
    S_PBYTE = 3'b100,
    S_DONE  = 3'b101
  } cmr_state_e;
  // Memory request carrier
  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cmr_mreq_s;
endpackage : cmr_pkg

// ---- tb/cmr_asserts.sv ----
// Port checker of the move engine
`timescale 1ns/1ns
`default_nettype none
module cmr_asserts
  import cmr_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  input  wire cmr_mreq_s   MEM_REQ,
  input  wire logic        MEM_VALID,
  input  wire logic        MEM_READY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  logic [31:0] step;
  // Operand length of the request on the bus
  assign step = (MEM_REQ.size == SZ_LONG) ? LEN_LONG : LEN_WORD;
  // Two byte cycles of one peripheral move
  sequence s_byte_pair;
    MEM_VALID && MEM_READY && MEM_REQ.size == SZ_BYTE
    ##2 MEM_VALID && MEM_REQ.size == SZ_BYTE;
  endsequence
  // Two cycles of one register list move
  sequence s_list_pair;
    MEM_VALID && MEM_READY && MEM_REQ.size != SZ_BYTE
    ##2 MEM_VALID && MEM_REQ.size != SZ_BYTE;
  endsequence
  AST_REQ_HOLD: assert property (
    MEM_VALID && !MEM_READY |=> MEM_VALID && $stable(MEM_REQ))
    else $error("memory request not held");
  AST_IDLE_GAP: assert property (
    MEM_VALID && MEM_READY |=> !MEM_VALID)
    else $error("no idle cycle after accept");
  AST_PB_STEP: assert property (
    s_byte_pair |-> MEM_REQ.addr == $past(MEM_REQ.addr, 2) + PB_STEP)
    else $error("byte address step wrong");
  AST_PB_LANES: assert property (
    MEM_VALID && MEM_REQ.we && MEM_REQ.size == SZ_BYTE
    |-> MEM_REQ.wdata == {4{MEM_REQ.wdata[7:0]}})
    else $error("byte not in all lanes");
  AST_LIST_STEP: assert property (
    s_list_pair |-> MEM_REQ.addr == $past(MEM_REQ.addr, 2) + step
    || MEM_REQ.addr == $past(MEM_REQ.addr, 2) - step)
    else $error("list address step wrong");
  AST_SLVERR: assert property (
    PSEL && PENABLE && PADDR > OFS_GR_DATA |-> PSLVERR)
    else $error("unmapped access without error");
  AST_NOERR: assert property (
    PSEL && PENABLE && PADDR <= OFS_GR_DATA && PADDR[1:0] == 2'h0
    |-> !PSLVERR)
    else $error("mapped access with error");
  AST_RD_ZERO: assert property (
    !(PSEL && PENABLE && !PWRITE) |-> PRDATA == 32'h0)
    else $error("read data outside read access");
  AST_READY: assert property (
    PSEL && PENABLE |-> PREADY)
    else $error("access not answered");
endmodule : cmr_asserts
bind cmr_engine cmr_asserts u_asserts (
  .REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
  .PREADY, .PSLVERR, .MEM_REQ, .MEM_VALID, .MEM_READY
);
`default_nettype wire

// ---- tb/cmr_mem_model.sv ----
// Memory and peripheral bus model with random answer latency
`timescale 1ns/1ns
`default_nettype none
module cmr_mem_model
  import cmr_pkg::*;
(
  input  wire logic      REF_CLK,
  input  wire logic      SYS_RST,
  input  wire cmr_mreq_s mem_req,
  input  wire logic      mem_valid,
  output logic           mem_ready,
  output logic [31:0]    mem_rdata
);
  logic [1:0]  wait_q;
  logic [31:0] junk_q;
  // One ready pulse per request after 1 to 4 cycles
  always @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mem_ready <= 1'b0;
      wait_q    <= 2'h0;
      junk_q    <= 32'h5a5a5a5a;
    end else begin
      junk_q <= ~junk_q + 32'h1;
      if (mem_ready) begin
        mem_ready <= 1'b0;
      end else if (mem_valid && wait_q == 2'h0) begin
        mem_ready <= 1'b1;
        wait_q    <= 2'($urandom_range(3));
      end else if (mem_valid) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
  // Image of the address while answering, noise otherwise
  assign mem_rdata = mem_ready ?
    {mem_req.addr[15:0], mem_req.addr[15:0] ^ 16'h8421} : junk_q;
endmodule : cmr_mem_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench of the move engine
`timescale 1ns/1ns
`default_nettype none
module testbench import cmr_pkg::*;;
  logic        REF_CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        MEM_VALID, MEM_READY, err;
  logic [7:0]  PADDR, b;
  logic [15:0] dsp;
  logic [31:0] PWDATA, PRDATA, MEM_RDATA, rd, a, x, m;
  logic [31:0] gv [16];
  logic [11:0] cr [4] = '{CR_SRC_SPACE, CR_DST_SPACE,
                          CR_USER_SP, CR_VEC_BASE};
  logic [15:0] bad [3] = '{16'h4ca3, 16'h4899, 16'h48bc};
  cmr_mreq_s   MEM_REQ, e;
  cmr_mreq_s   exp_q [$];
  int          num_errors, compares, n;
  cmr_engine DUT (
    .REF_CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .MEM_REQ, .MEM_VALID, .MEM_READY,
    .MEM_RDATA
  );
  cmr_mem_model u_mem (
    .REF_CLK, .SYS_RST, .mem_req(MEM_REQ), .mem_valid(MEM_VALID),
    .mem_ready(MEM_READY), .mem_rdata(MEM_RDATA)
  );
  // Clock
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] seen, ex);
    compares++;
    if (seen !== ex) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  function automatic logic [31:0] img(input logic [31:0] ad);
    return {ad[15:0], ad[15:0] ^ 16'h8421};
  endfunction : img
  function automatic logic [31:0] sx(input logic [31:0] ad);
    logic [31:0] t;
    t = img(ad);
    return {{16{t[15]}}, t[15:0]};
  endfunction : sx
  // One APB transfer, answer taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= ad;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge REF_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 16);
    if (PREADY !== 1'b1) begin
      chk("pready", 32'h0, 32'h1);
      print_verdict();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb
  task automatic setg(input logic [3:0] i, input logic [31:0] v);
    gv[i] = v;
    apb(1'b1, OFS_GR_SEL, {28'h0, i});
    apb(1'b1, OFS_GR_DATA, v);
  endtask : setg
  task automatic ckg(input logic [3:0] i, input logic [31:0] v);
    apb(1'b1, OFS_GR_SEL, {28'h0, i});
    apb(1'b0, OFS_GR_DATA, 32'h0);
    chk("register", rd, v);
  endtask : ckg
  task automatic push(input logic w, input logic [1:0] sz,
                      input logic [31:0] ad, d);
    exp_q.push_back('{we: w, size: sz, addr: ad, wdata: d});
  endtask : push
  // Start one instruction and wait for its end
  task automatic run(input logic [15:0] op, ext, input logic sup,
                     input logic [1:0] st);
    int k;
    apb(1'b1, OFS_OPWORD, {16'h0, op});
    apb(1'b1, OFS_EXTWORD, {16'h0, ext});
    apb(1'b1, OFS_CTRL, {30'h0, 1'b1, sup});
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end while (rd[ST_DONE] !== 1'b1 && k < 100);
    if (rd[ST_DONE] !== 1'b1) begin
      chk("done", 32'h0, 32'h1);
      print_verdict();
    end
    chk("flags", {30'h0, rd[3:2]}, {30'h0, st});
    apb(1'b1, OFS_STATUS, 32'hf);
    chk("pending", exp_q.size(), 32'h0);
  endtask : run
  // Pair each accepted bus cycle with the oldest note
  always @(posedge REF_CLK) begin
    if (SYS_RST === 1'b0 && MEM_VALID === 1'b1 && MEM_READY === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("surplus cycle", 32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        chk("addr", MEM_REQ.addr, e.addr);
        chk("kind", 32'({MEM_REQ.we, MEM_REQ.size}), 32'({e.we, e.size}));
        if (e.we) chk("wdata", MEM_REQ.wdata, e.wdata);
      end
    end
  end
  // Main sequence
  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    SYS_RST = 1'b1;
    num_errors = 0;
    compares = 0;
    void'($urandom(32'h62336874));
    repeat (3) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, OFS_EADDR, 32'h7770);
    for (int i = 0; i < 16; i++) setg(4'(i), $urandom);
    $display("map test done");
    run(16'h4e7b, 16'h1801, 1'b0, 2'b10);
    run(16'h4e7b, 16'h1002, 1'b1, 2'b01);
    for (int i = 0; i < 4; i++) begin
      setg(4'h1, $urandom);
      run(16'h4e7b, {4'h1, cr[i]}, 1'b1, 2'b00);
      run(16'h4e7a, {4'ha, cr[i]}, 1'b1, 2'b00);
      ckg(4'ha, gv[1] & (i < 2 ? 32'((1 << SPACE_W) - 1) : '1));
    end
    $display("control move test done");
    setg(4'h8, 32'h1000);
    push(1'b1, SZ_LONG, 32'h1000, gv[0]);
    push(1'b1, SZ_LONG, 32'h1004, gv[2]);
    push(1'b1, SZ_LONG, 32'h1008, 32'h1000);
    run(16'h48d0, 16'h0105, 1'b1, 2'b00);
    setg(4'hb, 32'h2000);
    push(1'b1, SZ_WORD, 32'h1ffe, gv[15]);
    push(1'b1, SZ_WORD, 32'h1ffc, 32'h1ffe);
    push(1'b1, SZ_WORD, 32'h1ffa, gv[0]);
    run(16'h48a3, 16'h8011, 1'b1, 2'b00);
    ckg(4'hb, 32'h1ffa);
    setg(4'h9, 32'h1000);
    for (int i = 0; i < 3; i++) push(1'b0, SZ_WORD, 32'h1000 + 32'(2 * i), 0);
    run(16'h4c99, 16'h0208, 1'b1, 2'b00);
    ckg(4'h3, sx(32'h1000));
    ckg(4'h9, sx(32'h1002) + 32'h2);
    // Displacement load and absolute store start at the given address
    for (int i = 0; i < 3; i++) push(1'b0, SZ_LONG, 32'h7770 + 32'(4 * i), 0);
    run(16'h4ce8, 16'h0011, 1'b1, 2'b00);
    ckg(4'h0, img(32'h7770));
    ckg(4'h4, img(32'h7774));
    push(1'b1, SZ_LONG, 32'h7770, gv[15]);
    run(16'h48f9, 16'h8000, 1'b1, 2'b00);
    foreach (bad[i]) run(bad[i], 16'h00ff, 1'b1, 2'b01);
    $display("list move test done");
    setg(4'hc, 32'h3000);
    for (int om = 4; om < 8; om++) begin
      dsp = (om[0] ^ om[1]) ? 16'h0000 : 16'hfffd;
      a = 32'h3000 + {{16{dsp[15]}}, dsp};
      n = om[0] ? 4 : 2;
      x = 32'h0;
      for (int i = 0; i < n; i++) begin
        m = img(a + 32'(2 * i));
        b = om[1] ? gv[5][8 * (n - 1 - i) +: 8] : (a[0] ? m[7:0] : m[15:8]);
        push(om[1], SZ_BYTE, a + 32'(2 * i), {4{b}});
        x = {x[23:0], b};
      end
      run({4'h0, om[1] ? 3'h5 : 3'h6, 3'(om), 6'h0c}, dsp, 1'b1, 2'b00);
      if (!om[1]) ckg(4'h6, om[0] ? x : {gv[6][31:16], x[15:0]});
      if (!om[1]) gv[6] = om[0] ? x : {gv[6][31:16], x[15:0]};
    end
    $display("peripheral move test done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
